// ---- hdl/charger_status_and_switch_ctrl.sv ----
// Purpose: Status pins, fault latch, interrupt pulse, battery switch and pulse protocol.
// Assumes: Analog conditions arrive asynchronously and are synchronised here.
// Notes: Long counts other than the interrupt pulse are top-level parameters so simulation can shorten them.
//
// Functional notes
// R1: Power good low only for good input.
// R2: Status pin low while charging.
// R3: Status pin released when done, asleep, disabled.
// R4: Status pin blinks 1 Hz on suspend faults.
// R5: Status pin disable bit stops driving it.
// R6: 256 us interrupt pulse on listed events.
// R7: Faults latch until fault register read.
// R8: No new fault interrupts until read and clear.
// R9: First read latched, second read present.
// R10: Thermistor fault field always live.
// R11: Switch-off bit opens switch, now or delayed.
// R12: Shipping mode exit events re-close switch.
// R13: Long button press resets system power.
// R14: Host sets enable, then one request bit.
// R15: Request bit busy, limit alternates with 100mA.
// R16: Sequence end restores limit, clears request.
// R17: Enable cleared aborts and restores at once.
// R18: Request writes ignored while enable low.
// R19: Pin limit applies smaller limit when enabled.
// R20: Thermal regulation flag, halved timer, no termination.
// R21: Thermal shutdown in buck: off, fault 10.
// R22: Thermal shutdown in boost opens the switch.
// R23: Input overvoltage: stop switching, fault 01.
// R24: Blink uses even duty from divided clock.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
module charger_status_and_switch_ctrl
   import chg_status_pkg::*;
#(
   parameter int unsigned BLINK_CYC   = BLINK_HALF_CYC,
   parameter longint unsigned HOLD_CYC = BTN_RST_CYC,
   parameter longint unsigned SHIP_CYC = SHIP_DLY_CYC,
   parameter int unsigned ROFF_CYC    = RST_OFF_CYC,
   parameter int unsigned DGL_CYC     = DEGLITCH_CYC,
   parameter int unsigned STEP_CYC    = PULSE_STEP_CYC
)
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Register port.
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // Analog conditions and pins.
   input  wire chg_cond_t   cond_async,
   input  wire logic        push_button_in,
   input  wire logic [5:0]  limit_resistor_pin,
   // Status outputs; open-drain pins are output plus enable.
   output logic             input_good_out_n,
   output logic             state_pin_out,
   output logic             state_pin_oe,
   output logic             int_pulse_n,
   // Power-stage controls.
   output logic             battery_switch,
   output logic             converter_on,
   output logic [5:0]       optimized_input_limit,
   output logic             thermal_reg_flag,
   output logic             timer_half_rate,
   output logic             termination_en
);

   logic          rst_s1_ff, rst_s2_ff;            // Reset release synchroniser.
   chg_cond_t     c_s1_ff, c_ff;                   // Condition synchroniser.
   logic          b_s1_ff, b_ff;                   // Button synchroniser.
   logic          rst_n;                           // Internal reset.
   chg_cond_t     c_d_ff;                          // Previous conditions, for edges.
   logic [15:0]   ctrl_ff, nxt_ctrl;               // Control bits.
   logic [5:0]    input_limit_setting_ff;          // Programmed input limit.
   logic [2:0]    thermal_reg_threshold_ff;        // Regulation threshold code.
   fault_img_t    fault_ff;                        // Latched fault image.
   logic          read_once_ff;                    // Fault register read since latch.
   logic [15:0]   rdata_ff;                        // Read data register.
   logic [31:0]   blink_cnt_ff;                    // Blink divider.
   logic          blink_ff;                        // Blink phase.
   logic [15:0]   int_cnt_ff;                      // Interrupt pulse timer.
   sw_state_t     sw_ff, nxt_sw;                   // Switch sequencer.
   logic [63:0]   sw_cnt_ff;                       // Switch sequencer timer.
   logic [63:0]   hold_cnt_ff;                     // Button low time.
   logic          btn_dgl_ff;                      // Deglitched button level.
   logic [31:0]   dgl_cnt_ff;                      // Deglitch counter.
   logic [31:0]   step_cnt_ff;                     // Pulse step timer.
   logic [3:0]    step_num_ff;                     // Pulse steps left.
   logic          pulse_low_ff;                    // Limit forced to 100 mA.

   // Reset released through two flip-flops.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n) begin rst_s1_ff <= 1'b0; rst_s2_ff <= 1'b0; end
      else          begin rst_s1_ff <= 1'b1; rst_s2_ff <= rst_s1_ff; end
   end
   assign rst_n = rst_s2_ff;

   // Asynchronous inputs pass two flip-flops before use.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         c_s1_ff <= '0; c_ff <= '0; c_d_ff <= '0; b_s1_ff <= 1'b1; b_ff <= 1'b1;
      end
      else
      begin
         c_s1_ff <= cond_async; c_ff <= c_s1_ff; c_d_ff <= c_ff;
         b_s1_ff <= push_button_in; b_ff <= b_s1_ff;
      end
   end

   // Decodes and live conditions.
   wire wr_ctrl   = wr && (addr == ADDR_CTRL);
   wire wr_limit  = wr && (addr == ADDR_LIMIT);
   wire rd_fault  = rd && (addr == ADDR_FAULT);
   wire good_in   = c_ff.in_uvlo_ok && c_ff.in_above_bat &&
                    !c_ff.in_overvoltage && !c_ff.poor_source;              // R1
   wire good_in_d = c_d_ff.in_uvlo_ok && c_d_ff.in_above_bat &&
                    !c_d_ff.in_overvoltage && !c_d_ff.poor_source;
   wire therm_live = |c_ff.thermistor_fault;
   wire suspend   = c_ff.in_overvoltage || c_ff.sys_ov || therm_live ||
                    c_ff.timer_fault;                                       // R4
   wire shut_buck = c_ff.thermal_shut && !c_ff.boost_mode;
   wire shut_boost = c_ff.thermal_shut && c_ff.boost_mode;

   // Present fault state, thermistor part always live.
   fault_img_t live_fault;
   assign live_fault.charge_fault_field = c_ff.in_overvoltage ? CF_INOV :  // R23
                                          shut_buck ? CF_SHUT :            // R21
                                          c_ff.timer_fault ? CF_TIMER : CF_NONE;
   assign live_fault.boost_fault = 1'b0;
   assign live_fault.bat_fault   = 1'b0;
   assign live_fault.thermistor_fault_field = c_ff.thermistor_fault;        // R10
   wire new_fault = (live_fault.charge_fault_field != CF_NONE) || therm_live;
   wire latched_any = (fault_ff.charge_fault_field != CF_NONE) ||
                      (fault_ff.thermistor_fault_field != 3'h0);
   // A fault interrupt is allowed only once the latch is read and empty.
   wire fault_arm  = !latched_any;                                          // R8
   wire fault_evt  = new_fault && fault_arm;
   wire other_evt  = (c_ff.source_id && !c_d_ff.source_id) ||
                     (good_in != good_in_d) ||                              // R6
                     (c_ff.charge_done && !c_d_ff.charge_done);

   // Fault latch: a fault sticks until a read; the read shows the latched image,
   // and afterwards the live state is captured so a second read shows it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) fault_ff <= '0;
      else if (rd_fault)
         fault_ff <= live_fault;                                           // R9
      else if (new_fault && !latched_any)
         fault_ff <= live_fault;                                           // R7
   end

   // Read data: the fault register returns the latched image, thermistor live.
   wire [15:0] rd_mux = (addr == ADDR_CTRL)   ? ctrl_ff :
                        (addr == ADDR_LIMIT)  ? {7'h00, thermal_reg_threshold_ff,
                                                 input_limit_setting_ff} :
                        (addr == ADDR_STATUS) ? {12'h000, thermal_reg_flag, good_in,
                                                 c_ff.charging, c_ff.charge_done} :
                        (addr == ADDR_FAULT)  ? {9'h000, fault_ff.charge_fault_field,
                                                 fault_ff.boost_fault, fault_ff.bat_fault,
                                                 c_ff.thermistor_fault} :     // R10
                        16'h0000;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) rdata_ff <= 16'h0000;
      else        rdata_ff <= rd ? rd_mux : 16'h0000;
   end
   assign rdata = rdata_ff;

   // Control writes. Request bits only accepted while enabled; the sequencer
   // clears them when done or aborted. Register reset returns defaults.
   wire pulse_end = (step_num_ff == 4'h0) && (step_cnt_ff == 32'h0) &&
                    (ctrl_ff[B_PULSE_UP] || ctrl_ff[B_PULSE_DN]);
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl)
      begin
         nxt_ctrl = {wdata[15:7], ctrl_ff[B_PULSE_DN:B_PULSE_UP], wdata[4:0]};
         if (wdata[B_PULSE_EN] && ctrl_ff[B_PULSE_EN] && !ctrl_ff[B_PULSE_UP] &&
             !ctrl_ff[B_PULSE_DN] && (wdata[B_PULSE_UP] != wdata[B_PULSE_DN]))
            nxt_ctrl[B_PULSE_DN:B_PULSE_UP] = wdata[B_PULSE_DN:B_PULSE_UP];  // R18
         nxt_ctrl[B_REG_RESET] = 1'b0;
         if (wdata[B_REG_RESET]) nxt_ctrl = CTRL_RESET;
      end
      if (!nxt_ctrl[B_PULSE_EN] || pulse_end)
         nxt_ctrl[B_PULSE_DN:B_PULSE_UP] = 2'b00;                         // R16 R17
      // A wake event also drops the off request, else shipping mode re-enters at once.
      if ((sw_ff == SW_SHIP) && (nxt_sw == SW_ON)) nxt_ctrl[B_SW_OFF] = 1'b0; // R12
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) ctrl_ff <= CTRL_RESET;
      else        ctrl_ff <= nxt_ctrl;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         input_limit_setting_ff   <= LIMIT_RESET;
         thermal_reg_threshold_ff <= THERMAL_REG_THRESHOLD_RESET;
      end
      else if (wr_limit)
      begin
         input_limit_setting_ff   <= wdata[5:0];
         thermal_reg_threshold_ff <= wdata[8:6];
      end
   end

   // Pulse sequencer: alternates the limit each step while a request is set.
   wire busy = ctrl_ff[B_PULSE_UP] || ctrl_ff[B_PULSE_DN];                 // R15
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step_cnt_ff <= 32'h0; step_num_ff <= 4'h0; pulse_low_ff <= 1'b0;
      end
      else if (!busy || !ctrl_ff[B_PULSE_EN])
      begin
         // Idle or aborted: the next start loads a full sequence.
         step_cnt_ff  <= STEP_CYC - 1;
         step_num_ff  <= nxt_ctrl[B_PULSE_UP] ? PULSE_STEPS_UP : PULSE_STEPS_DN;
         pulse_low_ff <= 1'b0;                                              // R17
      end
      else if (step_cnt_ff != 32'h0) step_cnt_ff <= step_cnt_ff - 32'h1;
      else if (step_num_ff != 4'h0)
      begin
         step_cnt_ff  <= STEP_CYC - 1;
         step_num_ff  <= step_num_ff - 4'h1;
         pulse_low_ff <= !pulse_low_ff;                                     // R15
      end
   end

   // Effective limit: smaller of pin and register when pin limiting is on.
   wire [5:0] prog_lim = (ctrl_ff[B_PIN_LIM_EN] && (limit_resistor_pin < input_limit_setting_ff))
                         ? limit_resistor_pin : input_limit_setting_ff;    // R19
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) optimized_input_limit <= LIMIT_RESET;
      else        optimized_input_limit <= (busy && pulse_low_ff) ? LIMIT_100MA : prog_lim;
   end

   // Thermal regulation effects and converter control.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         thermal_reg_flag <= 1'b0; timer_half_rate <= 1'b0;
         termination_en <= 1'b1; converter_on <= 1'b0;
      end
      else
      begin
         thermal_reg_flag <= c_ff.thermal_reg;                              // R20
         timer_half_rate  <= c_ff.thermal_reg;                              // R20
         termination_en   <= !c_ff.thermal_reg;                             // R20
         converter_on     <= !shut_buck && !c_ff.in_overvoltage && !c_ff.sys_ov; // R21 R23
      end
   end

   // Interrupt pulse timer; a new event restarts the 256 us low pulse.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) int_cnt_ff <= 16'h0;
      else if (fault_evt || other_evt) int_cnt_ff <= 16'(INT_PULSE_CYC);    // R6
      else if (int_cnt_ff != 16'h0)   int_cnt_ff <= int_cnt_ff - 16'h1;
   end
   assign int_pulse_n = (int_cnt_ff == 16'h0);

   // Blink divider, even duty, only runs while needed.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) begin blink_cnt_ff <= 32'h0; blink_ff <= 1'b0; end
      else if (!suspend) begin blink_cnt_ff <= 32'h0; blink_ff <= 1'b0; end
      else if (blink_cnt_ff == BLINK_CYC - 1)
      begin
         blink_cnt_ff <= 32'h0; blink_ff <= !blink_ff;                     // R24
      end
      else blink_cnt_ff <= blink_cnt_ff + 32'h1;
   end

   // Status pins, registered. Low means the enable is on and the output is zero.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) begin state_pin_oe <= 1'b0; input_good_out_n <= 1'b1; end
      else
      begin
         input_good_out_n <= !good_in;                                      // R1
         if (ctrl_ff[B_STATE_DIS])          state_pin_oe <= 1'b0;           // R5
         else if (suspend)                  state_pin_oe <= blink_ff;       // R4
         else if (c_ff.charging)            state_pin_oe <= 1'b1;           // R2
         else                               state_pin_oe <= 1'b0;           // R3
      end
   end
   assign state_pin_out = 1'b0;

   // Button deglitch and hold timer.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) begin btn_dgl_ff <= 1'b1; dgl_cnt_ff <= 32'h0; hold_cnt_ff <= 64'h0; end
      else
      begin
         if (b_ff == btn_dgl_ff) dgl_cnt_ff <= 32'h0;
         else if (dgl_cnt_ff == DGL_CYC - 1) begin btn_dgl_ff <= b_ff; dgl_cnt_ff <= 32'h0; end
         else dgl_cnt_ff <= dgl_cnt_ff + 32'h1;
         if (b_ff || good_in || sw_ff != SW_ON) hold_cnt_ff <= 64'h0;
         else if (hold_cnt_ff != HOLD_CYC) hold_cnt_ff <= hold_cnt_ff + 64'h1;
      end
   end
   wire btn_fall = btn_dgl_ff && !b_ff && (dgl_cnt_ff == DGL_CYC - 1);

   // Switch sequencer.
   always_comb
   begin
      nxt_sw = sw_ff;
      case (sw_ff)
         SW_ON:
            if (shut_buck || shut_boost) nxt_sw = (shut_boost ? SW_HOT : SW_ROFF); // R21 R22
            else if (ctrl_ff[B_SW_OFF]) nxt_sw = ctrl_ff[B_SW_DLY] ? SW_WAIT : SW_SHIP; // R11
            else if (ctrl_ff[B_BTN_RST_EN] && hold_cnt_ff == HOLD_CYC - 1)
               nxt_sw = SW_ROFF;                                            // R13
         SW_WAIT:
            if (!ctrl_ff[B_SW_OFF]) nxt_sw = SW_ON;
            else if (sw_cnt_ff == SHIP_CYC - 1) nxt_sw = SW_SHIP;           // R11
         SW_SHIP, SW_HOT:
            if (good_in || !ctrl_ff[B_SW_OFF] && sw_ff == SW_SHIP || btn_fall ||
                (sw_ff == SW_HOT && !c_ff.thermal_shut && wr_ctrl && wdata[B_REG_RESET]))
               nxt_sw = SW_ON;                                              // R12 R22
         SW_ROFF:
            if (!shut_buck && sw_cnt_ff >= ROFF_CYC - 1) nxt_sw = SW_ON;    // R13 R21
         default: nxt_sw = SW_ON;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) begin sw_ff <= SW_ON; sw_cnt_ff <= 64'h0; end
      else
      begin
         sw_ff     <= nxt_sw;
         sw_cnt_ff <= (nxt_sw != sw_ff) ? 64'h0 : sw_cnt_ff + 64'h1;
      end
   end
   assign battery_switch = (sw_ff == SW_ON) || (sw_ff == SW_WAIT);

   // Assertions.
   property p_pg; @(posedge clk) disable iff (!rst_n)
      !good_in |=> input_good_out_n; endproperty
   a_pg: assert property (p_pg) else $error("power good low with bad input"); // R1
   property p_chg; @(posedge clk) disable iff (!rst_n)
      c_ff.charging && !suspend && !ctrl_ff[B_STATE_DIS] |=> state_pin_oe; endproperty
   a_chg: assert property (p_chg) else $error("status not low while charging"); // R2
   property p_dis; @(posedge clk) disable iff (!rst_n)
      ctrl_ff[B_STATE_DIS] |=> !state_pin_oe; endproperty
   a_dis: assert property (p_dis) else $error("status pin driven while disabled"); // R5
   property p_int; @(posedge clk) disable iff (!rst_n)
      $fell(int_pulse_n) |-> !int_pulse_n [*8]; endproperty
   a_int: assert property (p_int) else $error("interrupt pulse too short"); // R6
   property p_lim; @(posedge clk) disable iff (!rst_n)
      !busy |=> optimized_input_limit == $past(prog_lim); endproperty
   a_lim: assert property (p_lim) else $error("limit not restored"); // R17
   property p_ign; @(posedge clk) disable iff (!rst_n)
      !ctrl_ff[B_PULSE_EN] |=> !busy; endproperty
   a_ign: assert property (p_ign) else $error("request taken while disabled"); // R18
   property p_therm; @(posedge clk) disable iff (!rst_n)
      c_ff.thermal_reg |=> thermal_reg_flag && timer_half_rate && !termination_en; endproperty
   a_therm: assert property (p_therm) else $error("thermal regulation effects missing"); // R20
   property p_ov; @(posedge clk) disable iff (!rst_n)
      c_ff.in_overvoltage |=> !converter_on; endproperty
   a_ov: assert property (p_ov) else $error("converter on during overvoltage"); // R23
   property p_ship; @(posedge clk) disable iff (!rst_n)
      sw_ff == SW_ON && ctrl_ff[B_SW_OFF] && !ctrl_ff[B_SW_DLY] && !c_ff.thermal_shut
      |=> !battery_switch; endproperty
   a_ship: assert property (p_ship) else $error("switch not opened"); // R11
   c_blink: cover property (@(posedge clk) disable iff (!rst_n) $rose(blink_ff));
   c_pulse: cover property (@(posedge clk) disable iff (!rst_n) pulse_end);
   c_rst:   cover property (@(posedge clk) disable iff (!rst_n) sw_ff == SW_ROFF);

endmodule : charger_status_and_switch_ctrl

// ---- hdl/chg_status_pkg.sv ----
// Purpose: Shared constants and types for the charger status and switch control block.
// Assumes: 200 MHz core clock; register port with one-cycle read latency.
// Notes: Timing counts are derived from times in their own units.
package chg_status_pkg;

   // Clock rate in kHz, used to derive cycle counts.
   localparam int unsigned CLK_KHZ          = 200000;
   // Interrupt pulse width in microseconds.
   localparam int unsigned INT_PULSE_US     = 256;
   localparam int unsigned INT_PULSE_CYC    = INT_PULSE_US * (CLK_KHZ / 1000);
   // Half period of the 1 Hz blink, in milliseconds.
   localparam int unsigned BLINK_HALF_MS    = 500;
   localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * CLK_KHZ;
   // Push-button reset hold time in seconds.
   localparam int unsigned BTN_RST_S        = 15;
   localparam longint unsigned BTN_RST_CYC  = 64'(BTN_RST_S) * 64'(CLK_KHZ) * 64'd1000;
   // Shipping-mode delay, switch reset-off time and button deglitch, in ms.
   localparam int unsigned SHIP_DLY_MS      = 10000;
   localparam longint unsigned SHIP_DLY_CYC = 64'(SHIP_DLY_MS) * 64'(CLK_KHZ);
   localparam int unsigned RST_OFF_MS       = 250;
   localparam int unsigned RST_OFF_CYC      = RST_OFF_MS * CLK_KHZ;
   localparam int unsigned DEGLITCH_MS      = 1000;
   localparam int unsigned DEGLITCH_CYC     = DEGLITCH_MS * CLK_KHZ;
   // Length of one step of the pulse protocol, in ms, and the number of steps.
   localparam int unsigned PULSE_STEP_MS    = 100;
   localparam int unsigned PULSE_STEP_CYC   = PULSE_STEP_MS * CLK_KHZ;
   localparam logic [3:0]  PULSE_STEPS_UP   = 4'h6;
   localparam logic [3:0]  PULSE_STEPS_DN   = 4'h3;

   // Register offsets.
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_LIMIT  = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_FAULT  = 4'h3;

   // Control register bit positions.
   localparam int unsigned B_STATE_DIS   = 0;
   localparam int unsigned B_SW_OFF      = 1;
   localparam int unsigned B_SW_DLY      = 2;
   localparam int unsigned B_BTN_RST_EN  = 3;
   localparam int unsigned B_PULSE_EN    = 4;
   localparam int unsigned B_PULSE_UP    = 5;
   localparam int unsigned B_PULSE_DN    = 6;
   localparam int unsigned B_PIN_LIM_EN  = 7;
   localparam int unsigned B_REG_RESET   = 8;
   localparam logic [15:0] CTRL_RESET    = 16'h0088;

   // Input limit field and the fixed low limit used while pulsing (100 mA, 50 mA steps).
   localparam logic [5:0] LIMIT_RESET    = 6'h08;
   localparam logic [5:0] LIMIT_100MA    = 6'h01;
   localparam logic [2:0] THERMAL_REG_THRESHOLD_RESET     = 3'h3;

   // Charge fault field codes.
   localparam logic [1:0] CF_NONE  = 2'h0;
   localparam logic [1:0] CF_INOV  = 2'h1;
   localparam logic [1:0] CF_SHUT  = 2'h2;
   localparam logic [1:0] CF_TIMER = 2'h3;

   // Live conditions coming from the analog side.
   typedef struct packed {
      logic       in_uvlo_ok;
      logic       in_above_bat;
      logic       in_overvoltage;
      logic       poor_source;
      logic       charging;
      logic       charge_done;
      logic       sleep;
      logic       charge_dis;
      logic       sys_ov;
      logic       timer_fault;
      logic       boost_mode;
      logic       thermal_reg;
      logic       thermal_shut;
      logic       source_id;
      logic [2:0] thermistor_fault;
   } chg_cond_t;

   // Fault register image.
   typedef struct packed {
      logic [1:0] charge_fault_field;
      logic       boost_fault;
      logic       bat_fault;
      logic [2:0] thermistor_fault_field;
   } fault_img_t;

   // Switch sequencer states.
   typedef enum logic [4:0] {
      SW_ON   = 5'h01,
      SW_WAIT = 5'h02,
      SW_SHIP = 5'h04,
      SW_ROFF = 5'h08,
      SW_HOT  = 5'h10
   } sw_state_t;

endpackage : chg_status_pkg

// ---- test/chg_host_pins.sv ----
// Purpose: Host-side view of the open-drain status pin and interrupt line.
// Assumes: Both lines carry pull-ups on the host board.
// Notes: The host only listens here, so a released pin must read high.
`timescale 1ns/10ps
module chg_host_pins
(
   // Pins from the charger.
   input  wire logic state_pin_oe,
   input  wire logic int_pulse_n,
   // Levels the host sees.
   output logic      state_level,
   output logic      int_level
);
   // The pull-up wins whenever the charger lets go, never a stale value.
   assign state_level = state_pin_oe ? 1'b0 : 1'b1;
   assign int_level   = int_pulse_n;
endmodule : chg_host_pins

// ---- test/charger_status_and_switch_ctrl_bench.sv ----
// Purpose: Self-checking bench for the charger status and switch block.
// Assumes: Long counts except the interrupt pulse shortened to 16 cycles each.
// Notes: Register writes keep CTRL_RESET defaults except the bits under test.
`timescale 1ns/10ps
`define CHK(g,e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module charger_status_and_switch_ctrl_bench import chg_status_pkg::*;;
   logic        clk = 0, reset_n = 0, wr = 0, rd = 0, push_button_in = 1, seen;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, q;
   logic [5:0]  pin = 6'h3F, lim;
   chg_cond_t   cond = '0;
   logic        good_n, oe, so, int_n, sw, lvl, il, conv, trf, thr, ten;
   int          err_total = 0, num_checks = 0, cyc = 0, n;
   always #2.5 clk = ~clk;
   charger_status_and_switch_ctrl #(.BLINK_CYC(16), .HOLD_CYC(16), .SHIP_CYC(16), .ROFF_CYC(16),
      .DGL_CYC(16), .STEP_CYC(16)) i_charger_status_and_switch_ctrl (.clk(clk), .reset_n(reset_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cond_async(cond),
      .push_button_in(push_button_in), .limit_resistor_pin(pin), .input_good_out_n(good_n),
      .state_pin_out(so), .state_pin_oe(oe), .int_pulse_n(int_n), .battery_switch(sw),
      .converter_on(conv), .optimized_input_limit(lim), .thermal_reg_flag(trf),
      .timer_half_rate(thr), .termination_en(ten));
   chg_host_pins i_chg_host_pins (.state_pin_oe(oe), .int_pulse_n(int_n), .state_level(lvl),
      .int_level(il));
   task cy(input int k); repeat (k) @(posedge clk); endtask : cy
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask : wr_reg
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task rd_reg(input logic [3:0] a);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0; #1 q = rdata;
   endtask : rd_reg
   task t_reset;
      rd_reg(ADDR_CTRL); `CHK(q, CTRL_RESET)
      `CHK(sw, 1'b1) `CHK(lim, LIMIT_RESET)
      rd_reg(4'hF); `CHK(q, 16'h0000)
      $display("reset done");
   endtask : t_reset
   task t_good;
      @(posedge clk); cond.in_uvlo_ok <= 1'b1; cond.in_above_bat <= 1'b1; cy(8);
      `CHK(good_n, 1'b0)
      `CHK(il, 1'b0)
      cond.poor_source <= 1'b1; cy(8); `CHK(good_n, 1'b1)
      cond.poor_source <= 1'b0; cond.in_uvlo_ok <= 1'b0; cy(8);
      $display("good input done");
   endtask : t_good
   task t_stat;
      cond.charging <= 1'b1; cy(8); `CHK(lvl, 1'b0) `CHK(so, 1'b0)
      wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0001); cy(4); `CHK(lvl, 1'b1)
      wr_reg(ADDR_CTRL, CTRL_RESET); cond.charging <= 1'b0; cond.charge_done <= 1'b1;
      cy(8); `CHK(lvl, 1'b1)
      cond.charge_done <= 1'b0; cond.timer_fault <= 1'b1; cy(8); n = 0;
      repeat (128) @(posedge clk) n += lvl;
      `CHK((n > 40 && n < 88), 1'b1)
      cond.timer_fault <= 1'b0; cy(8);
      $display("status pin done");
   endtask : t_stat
   task t_fault;
      rd_reg(ADDR_FAULT); rd_reg(ADDR_FAULT);
      cond.in_overvoltage <= 1'b1; cy(8); cond.in_overvoltage <= 1'b0; cy(8);
      rd_reg(ADDR_FAULT); `CHK(q[6:5], CF_INOV)
      rd_reg(ADDR_FAULT); `CHK(q[6:5], CF_NONE)
      cond.thermistor_fault <= 3'h5; cy(8); rd_reg(ADDR_FAULT); `CHK(q[2:0], 3'h5)
      cond.thermistor_fault <= 3'h0; cy(8);
      rd_reg(ADDR_FAULT); `CHK(q[2:0], 3'h0)
      $display("fault done");
   endtask : t_fault
   task t_pulse;
      wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0020); rd_reg(ADDR_CTRL); `CHK(q[5], 1'b0)
      wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0010); wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0030);
      rd_reg(ADDR_CTRL); `CHK(q[5], 1'b1)
      seen = 0; repeat (60) @(posedge clk) seen |= (lim === LIMIT_100MA);
      `CHK(seen, 1'b1)
      cy(150); rd_reg(ADDR_CTRL); `CHK(q[5], 1'b0)
      `CHK(lim, LIMIT_RESET)
      wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0050); cy(20); wr_reg(ADDR_CTRL, CTRL_RESET); cy(3);
      `CHK(lim, LIMIT_RESET)
      pin <= 6'h04; cy(8); `CHK(lim, 6'h04)
      wr_reg(ADDR_CTRL, 16'h0008); cy(4); `CHK(lim, LIMIT_RESET)
      wr_reg(ADDR_CTRL, CTRL_RESET); pin <= 6'h3F;
      $display("pulse and limit done");
   endtask : t_pulse
   task t_switch;
      wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0002); cy(4); `CHK(sw, 1'b0)
      cond.in_uvlo_ok <= 1'b1; cy(8); `CHK(sw, 1'b1)
      cond.in_uvlo_ok <= 1'b0; wr_reg(ADDR_CTRL, CTRL_RESET | 16'h0006); cy(4);
      `CHK(sw, 1'b1)
      cy(40); `CHK(sw, 1'b0)
      wr_reg(ADDR_CTRL, CTRL_RESET); cy(4); `CHK(sw, 1'b1)
      push_button_in <= 1'b0; seen = 0; repeat (200) @(posedge clk) seen |= (sw === 1'b0);
      `CHK(seen, 1'b1)
      push_button_in <= 1'b1; cy(60); `CHK(sw, 1'b1)
      $display("switch done");
   endtask : t_switch
   task t_therm;
      cond.thermal_reg <= 1'b1; cy(8); `CHK({trf, thr, ten}, 3'b110)
      cond.thermal_reg <= 1'b0; cond.thermal_shut <= 1'b1; cy(8); `CHK({conv, sw}, 2'b00)
      cond.thermal_shut <= 1'b0; cy(30); `CHK({conv, sw}, 2'b11)
      rd_reg(ADDR_FAULT); `CHK(q[6:5], CF_SHUT)
      cond.boost_mode <= 1'b1; cond.thermal_shut <= 1'b1; cy(8); `CHK(sw, 1'b0)
      cond.thermal_shut <= 1'b0; cy(30); `CHK(sw, 1'b0)
      wr_reg(ADDR_CTRL, 16'h0100); cy(4); `CHK(sw, 1'b1)
      $display("thermal done");
   endtask : t_therm
   task stop_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   // A hang counts as a failure and still reaches the verdict.
   always @(posedge clk) if (++cyc == 20000) begin err_total++; stop_test; end
   initial begin
      cy(2); reset_n <= 1'b1; cy(6);
      t_reset; t_good; t_stat; t_fault; t_pulse; t_switch; t_therm; stop_test;
   end
endmodule : charger_status_and_switch_ctrl_bench
